// >>> verilog/board_reset_pkg.sv
// board reset/configuration block: shared constants and carrier types
// assumes a byte-wide local-bus register port and one 50 MHz clock
package board_reset_pkg;

   localparam int CLOCK_HZ   = 50000000;
   localparam int ADDR_W     = 5;
   localparam int DATA_W     = 8;
   localparam int CFG_REGS   = 4;

   localparam logic [4:0] CFG0_ADDR       = 5'h00;
   localparam logic [4:0] CFG1_ADDR       = 5'h01;
   localparam logic [4:0] CFG2_ADDR       = 5'h02;
   localparam logic [4:0] CFG3_ADDR       = 5'h03;
   localparam logic [4:0] MODE_ADDR       = 5'h05;
   localparam logic [4:0] RESET_CTRL_ADDR = 5'h06;
   localparam logic [4:0] STATUS_ADDR     = 5'h07;
   localparam logic [4:0] REVISION_ADDR   = 5'h0E;

   // reset control register fields
   localparam int POR_BIT       = 7;
   localparam int REQ_EN_BIT    = 0;
   localparam int RTC_SOFT_BIT  = 1;
   localparam int CFG_RESET_BIT = 2;
   localparam logic [7:0] RESET_CTRL_INIT = 8'h80;
   // mode register fields
   localparam int SRC_REG_BIT   = 0;
   localparam int PCI_EN_BIT    = 1;
   localparam logic [7:0] MODE_INIT = 8'h00;

   // revision codes: arbitrary values
   localparam logic [3:0] MAJOR_REVISION = 4'h1;
   localparam logic [3:0] MINOR_REVISION = 4'h0;

   // hold of generated resets after sources end
   localparam int HARD_HOLD_US    = 100;
   localparam int HARD_HOLD_CYC   = (HARD_HOLD_US * (CLOCK_HZ / 1000000));
   localparam int SOFT_HOLD_US    = 10;
   localparam int SOFT_HOLD_CYC   = (SOFT_HOLD_US * (CLOCK_HZ / 1000000));
   localparam int CNT_W           = 16;

   typedef struct packed {
      logic powerOnReq;
      logic hardReq;
      logic softReq;
   } reset_req_s;

   typedef enum logic [1:0] {
      ST_POWER_ON = 2'b00,
      ST_HARD     = 2'b01,
      ST_SOFT     = 2'b10,
      ST_RUN      = 2'b11
   } seq_state_e;

endpackage : board_reset_pkg

// >>> verilog/reset_hold_timer.sv
// stretches a reset request: output stays asserted for a fixed count after request ends
// assumes request is synchronous to clock
`timescale 1ns/10ps
`default_nettype none
module reset_hold_timer
   import board_reset_pkg::*;
#(
   parameter int HOLD = 16
)
(
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic request,
   output logic      active
);
   logic [CNT_W-1:0] count;

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         // a block reset counts as a request that has just ended
         count <= CNT_W'(HOLD);
      end
      else if (request)
      begin
         count <= CNT_W'(HOLD);
      end
      else if (count != '0)
      begin
         count <= count - 1'b1;
      end
   end

   assign active = request || (count != '0);
endmodule : reset_hold_timer
`default_nettype wire

// >>> verilog/board_reset_config.sv
// board reset sequencer, reset-configuration register bank and PCI clock select
// assumes all pin inputs synchronous to clock; bus strobes are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module board_reset_config
   import board_reset_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              reset,
   // local bus register port
   input  wire logic              board_chip_select,
   input  wire logic              writeStrobe,
   input  wire logic              readStrobe,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic [DATA_W-1:0] writeData,
   output logic      [DATA_W-1:0] readData,
   // reset sources, active low; edge_connector_present is active high
   input  wire logic              supervisorReset_n,
   input  wire logic              probeHardReset_n,
   input  wire logic              probeSoftReset_n,
   input  wire logic              hardButton_n,
   input  wire logic              softButton_n,
   input  wire logic              pci_host_reset_n,
   input  wire logic              cpu_reset_request_n,
   input  wire logic              rtcAlarm_n,
   input  wire logic              edge_connector_present,
   // configuration switches
   input  wire logic [DATA_W-1:0] dipSwitch [CFG_REGS],
   // reset outputs, active low; then configuration word, PCI clock and config source selects, active high
   output logic                   power_on_reset_n,
   output logic                   hard_reset_n,
   output logic                   soft_reset_n,
   output logic [DATA_W-1:0]      reset_config_signals [CFG_REGS],
   output logic                   pciClockFromEdge,
   output logic                   configFromRegisters
);

   logic [DATA_W-1:0] cfgReg [CFG_REGS];
   logic [DATA_W-1:0] resetCtrl;
   logic [DATA_W-1:0] modeReg;
   logic [DATA_W-1:0] next_readData;
   logic              hardPrev;
   logic              reloadPending;
   logic              cfgDirty;
   logic              cfgWrite;
   logic              hardHeld;
   logic              softHeld;
   reset_req_s        req;
   seq_state_e        state;

   wire logic [4:0] regSel = address;

   // request merging
   always_comb
   begin
      req.powerOnReq = !supervisorReset_n
                    || !resetCtrl[POR_BIT]
                    || (edge_connector_present && !pci_host_reset_n);
      req.hardReq    = !probeHardReset_n || !hardButton_n
                    || (modeReg[PCI_EN_BIT] && !pci_host_reset_n)
                    || (resetCtrl[REQ_EN_BIT] && !cpu_reset_request_n)
                    || (!resetCtrl[RTC_SOFT_BIT] && !rtcAlarm_n)
                    || (resetCtrl[CFG_RESET_BIT] && cfgDirty);
      req.softReq    = !probeSoftReset_n || !softButton_n
                    || (resetCtrl[RTC_SOFT_BIT] && !rtcAlarm_n);
   end

   // power-on keeps everything in reset; hard and soft follow with hold
   reset_hold_timer #(
      .HOLD (HARD_HOLD_CYC)
   ) hardTimer (
      .clock   (clock),
      .reset   (reset),
      .request (req.powerOnReq || req.hardReq),
      .active  (hardHeld)
   );

   reset_hold_timer #(
      .HOLD (SOFT_HOLD_CYC)
   ) softTimer (
      .clock   (clock),
      .reset   (reset),
      .request (hardHeld || req.softReq),
      .active  (softHeld)
   );

   // sequence state, visible in status register
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state <= ST_POWER_ON;
      end
      else
      begin
         case (state)
            ST_POWER_ON: if (!req.powerOnReq) state <= ST_HARD;
            ST_HARD:     if (req.powerOnReq) state <= ST_POWER_ON;
                         else if (!hardHeld) state <= ST_SOFT;
            ST_SOFT:     if (req.powerOnReq) state <= ST_POWER_ON;
                         else if (hardHeld) state <= ST_HARD;
                         else if (!softHeld) state <= ST_RUN;
            ST_RUN:      if (req.powerOnReq) state <= ST_POWER_ON;
                         else if (hardHeld) state <= ST_HARD;
                         else if (softHeld) state <= ST_SOFT;
            default:     state <= ST_POWER_ON;
         endcase
      end
   end

   // reset outputs, registered
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         power_on_reset_n <= 1'b0;
         hard_reset_n     <= 1'b0;
         soft_reset_n     <= 1'b0;
      end
      else
      begin
         power_on_reset_n <= !req.powerOnReq;
         hard_reset_n     <= !(hardHeld || state == ST_POWER_ON);
         soft_reset_n     <= !(softHeld || state == ST_POWER_ON);
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         hardPrev <= 1'b0;
      end
      else
      begin
         hardPrev <= !hard_reset_n;
      end
   end

   // switch reload owed after power-on, spent at the next hard release
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         reloadPending <= 1'b1;
      end
      else if (state == ST_POWER_ON)
      begin
         reloadPending <= 1'b1;
      end
      else if (hardPrev && hard_reset_n)
      begin
         reloadPending <= 1'b0;
      end
   end

   assign cfgWrite = board_chip_select && writeStrobe && (regSel < 5'(CFG_REGS));

   // configuration registers; switch capture on hard release after power-on
   generate
      for (genvar i = 0; i < CFG_REGS; i++)
      begin : cfgBank
         always_ff @(posedge clock or posedge reset)
         begin
            if (reset)
            begin
               cfgReg[i] <= 8'h00;
            end
            else if (board_chip_select && writeStrobe && regSel == 5'(i))
            begin
               cfgReg[i] <= writeData;
            end
            else if (hardPrev && hard_reset_n && reloadPending && !modeReg[SRC_REG_BIT])
            begin
               cfgReg[i] <= dipSwitch[i];
            end
         end
         assign reset_config_signals[i] = cfgReg[i];
      end
   endgenerate

   // pending software change: cleared as the new word is taken by a hard reset
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         cfgDirty <= 1'b0;
      end
      else if (cfgWrite)
      begin
         cfgDirty <= 1'b1;
      end
      else if (!hard_reset_n)
      begin
         cfgDirty <= 1'b0;
      end
   end

   // control registers; power-on restores the mode default only (reset control keeps all but its POR bit), hard reset keeps them
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         resetCtrl <= RESET_CTRL_INIT;
         modeReg   <= MODE_INIT;
      end
      else
      begin
         if (board_chip_select && writeStrobe && regSel == RESET_CTRL_ADDR)
         begin
            resetCtrl <= writeData;
         end
         else if (!resetCtrl[POR_BIT])
         begin
            resetCtrl[POR_BIT] <= 1'b1;
         end
         if (board_chip_select && writeStrobe && regSel == MODE_ADDR)
         begin
            modeReg <= writeData;
         end
         else if (req.powerOnReq)
         begin
            modeReg <= MODE_INIT;
         end
      end
   end

   // read path
   always_comb
   begin
      next_readData = 8'h00;
      case (regSel)
         CFG0_ADDR:       next_readData = cfgReg[0];
         CFG1_ADDR:       next_readData = cfgReg[1];
         CFG2_ADDR:       next_readData = cfgReg[2];
         CFG3_ADDR:       next_readData = cfgReg[3];
         MODE_ADDR:       next_readData = modeReg;
         RESET_CTRL_ADDR: next_readData = resetCtrl;
         STATUS_ADDR:     next_readData = {edge_connector_present, cfgDirty, 4'h0, state};
         REVISION_ADDR:   next_readData = {MINOR_REVISION, MAJOR_REVISION};
         default:         next_readData = 8'h00;
      endcase
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         readData <= 8'h00;
      end
      else if (board_chip_select && readStrobe)
      begin
         readData <= next_readData;
      end
   end

   // clock switch and configuration source select
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         pciClockFromEdge    <= 1'b0;
         configFromRegisters <= 1'b0;
      end
      else
      begin
         pciClockFromEdge    <= edge_connector_present;
         configFromRegisters <= modeReg[SRC_REG_BIT];
      end
   end

endmodule : board_reset_config
`default_nettype wire

// >>> verif/host_bus_model.sv
// host processor side of the local bus: byte reads and writes into the register bank
// assumes strobes are taken on the rising edge and read data follows a cycle later
`timescale 1ns/10ps
`default_nettype none
module host_bus_model
   import board_reset_pkg::*;
(
   input  wire logic              clock,
   output logic                   board_chip_select,
   output logic                   writeStrobe,
   output logic                   readStrobe,
   output logic [ADDR_W-1:0]      address,
   output logic [DATA_W-1:0]      writeData,
   input  wire logic [DATA_W-1:0] readData
);
   initial
   begin
      board_chip_select = 1'b0;
      writeStrobe = 1'b0;
      readStrobe = 1'b0;
      address = 5'h1F;
      writeData = 8'h00;
   end
   // one strobe held across one rising edge, then released lines scrambled
   task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge clock);
      board_chip_select = 1'b1;
      writeStrobe = wr;
      readStrobe = !wr;
      address = a;
      writeData = d;
      @(negedge clock);
      board_chip_select = 1'b0;
      writeStrobe = 1'b0;
      readStrobe = 1'b0;
      address = ~address;
      writeData = ~writeData;
   endtask : access
   task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      access(1'b1, a, d);
   endtask : write
   task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      access(1'b0, a, 8'h00);
      @(negedge clock);
      d = readData;
   endtask : read
endmodule : host_bus_model
`default_nettype wire

// >>> verif/board_reset_config_chk.sv
// assertions on the reset outputs and register port of the board reset block
// assumes one clock domain and the async active-high reset
`timescale 1ns/10ps
`default_nettype none
module board_reset_config_chk
   import board_reset_pkg::*;
(
   input wire logic              clock,
   input wire logic              reset,
   input wire logic              board_chip_select,
   input wire logic              writeStrobe,
   input wire logic              readStrobe,
   input wire logic [ADDR_W-1:0] address,
   input wire logic [DATA_W-1:0] writeData,
   input wire logic [DATA_W-1:0] readData,
   input wire logic              supervisorReset_n,
   input wire logic              probeHardReset_n,
   input wire logic              hardButton_n,
   input wire logic              edge_connector_present,
   input wire logic              power_on_reset_n,
   input wire logic              hard_reset_n,
   input wire logic              soft_reset_n,
   input wire logic              pciClockFromEdge
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   supervisor_por_a: assert property (!supervisorReset_n |=> !power_on_reset_n)
      else $error("power-on reset missed supervisor");
   por_holds_a: assert property (!power_on_reset_n |=> !hard_reset_n && !soft_reset_n)
      else $error("hard or soft released under power-on");
   probe_hard_a: assert property (!probeHardReset_n |=> !hard_reset_n)
      else $error("probe hard request lost");
   button_hard_a: assert property (!hardButton_n |=> !hard_reset_n)
      else $error("hard button lost");
   hard_hold_a: assert property ($rose(hardButton_n) |-> !hard_reset_n [*8])
      else $error("hard reset not held");
   edge_clock_a: assert property (1'b1 |=> pciClockFromEdge == $past(edge_connector_present))
      else $error("pci clock source wrong");
   revision_read_a: assert property (board_chip_select && readStrobe && address == REVISION_ADDR
      |=> readData == {MINOR_REVISION, MAJOR_REVISION}) else $error("revision wrong");
   por_write_a: assert property (board_chip_select && writeStrobe && address == RESET_CTRL_ADDR
      && !writeData[POR_BIT] |-> ##[1:2] !power_on_reset_n) else $error("por write ignored");
endmodule : board_reset_config_chk
`default_nettype wire

// >>> verif/board_reset_config_bench.sv
// bench for the board reset block: reset sources, register bank, pci clock select
// assumes host_bus_model on the local bus and the checker bound at the foot
`timescale 1ns/10ps
`default_nettype none
module board_reset_config_bench
   import board_reset_pkg::*;
   ;
   logic              clock;
   logic              reset;
   logic [7:0]        srcN;
   logic              edgeOn;
   logic [DATA_W-1:0] dip [CFG_REGS];
   logic [DATA_W-1:0] cfgOut [CFG_REGS];
   logic              board_chip_select, writeStrobe, readStrobe;
   logic [ADDR_W-1:0] address;
   logic [DATA_W-1:0] writeData, readData, d;
   logic              power_on_reset_n, hard_reset_n, soft_reset_n, pciClockFromEdge, configFromRegisters;
   logic [2:0]        outs;
   int                n_fail = 0;
   int                total_checks = 0;
   assign outs = {power_on_reset_n, hard_reset_n, soft_reset_n};
   board_reset_config dut (.clock, .reset, .board_chip_select, .writeStrobe, .readStrobe, .address,
      .writeData, .readData, .supervisorReset_n(srcN[0]), .probeHardReset_n(srcN[1]),
      .probeSoftReset_n(srcN[2]), .hardButton_n(srcN[3]), .softButton_n(srcN[4]),
      .pci_host_reset_n(srcN[5]), .cpu_reset_request_n(srcN[6]), .rtcAlarm_n(srcN[7]),
      .edge_connector_present(edgeOn), .dipSwitch(dip), .power_on_reset_n, .hard_reset_n,
      .soft_reset_n, .reset_config_signals(cfgOut), .pciClockFromEdge, .configFromRegisters);
   host_bus_model host (.clock, .board_chip_select, .writeStrobe, .readStrobe, .address, .writeData,
      .readData);
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic waitIdle();
      for (int k = 0; k < 8000 && outs !== 3'b111; k++)
         @(negedge clock);
      check({5'h00, outs}, 8'h07);
   endtask : waitIdle
   // hold one source low, look at one output, then let everything recover
   task automatic hit(input int idx, input int out, input logic lvl);
      srcN[idx] = 1'b0;
      repeat (3) @(negedge clock);
      check({7'h00, outs[out]}, {7'h00, lvl});
      srcN[idx] = 1'b1;
      waitIdle();
   endtask : hit
   task automatic sawLow(input int out);
      logic s;
      s = 1'b0;
      repeat (4)
      begin
         s |= !outs[out];
         @(negedge clock);
      end
      check({7'h00, s}, 8'h01);
      waitIdle();
   endtask : sawLow
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial
   begin
      repeat (90000) @(posedge clock);
      n_fail++;
      tally_and_finish();
   end
   initial
   begin
      reset = 1'b1;
      srcN = 8'hFF;
      edgeOn = 1'b0;
      dip = '{8'hA5, 8'h3C, 8'h96, 8'h0F};
      repeat (3) @(negedge clock);
      reset = 1'b0;
      waitIdle();
      for (int i = 0; i < CFG_REGS; i++)
         check(cfgOut[i], dip[i]);
      host.read(CFG0_ADDR, d);
      check(d, dip[0]);
      host.read(REVISION_ADDR, d);
      check(d, {MINOR_REVISION, MAJOR_REVISION});
      host.write(5'h04, 8'hFF);
      host.read(5'h04, d);
      check(d, 8'h00);
      $display("register test done");
      host.write(MODE_ADDR, 8'h01);
      host.write(CFG0_ADDR, 8'h5A);
      host.read(CFG0_ADDR, d);
      check(d, 8'h5A);
      check({7'h00, configFromRegisters}, 8'h01);
      hit(3, 1, 1'b0);
      check(cfgOut[0], 8'h5A);
      host.write(RESET_CTRL_ADDR, 8'h84);
      host.write(CFG1_ADDR, 8'h33);
      sawLow(1);
      check(cfgOut[1], 8'h33);
      host.write(RESET_CTRL_ADDR, 8'h00);
      sawLow(2);
      $display("config test done");
      hit(0, 2, 1'b0);
      hit(1, 1, 1'b0);
      hit(2, 0, 1'b0);
      hit(4, 0, 1'b0);
      host.write(RESET_CTRL_ADDR, 8'h80);
      hit(6, 1, 1'b1);
      host.write(RESET_CTRL_ADDR, 8'h81);
      hit(6, 1, 1'b0);
      edgeOn = 1'b1;
      host.write(MODE_ADDR, 8'h02);
      hit(5, 1, 1'b0);
      check({7'h00, pciClockFromEdge}, 8'h01);
      edgeOn = 1'b0;
      repeat (2) @(negedge clock);
      check({7'h00, pciClockFromEdge}, 8'h00);
      host.write(RESET_CTRL_ADDR, 8'h82);
      hit(7, 0, 1'b0);
      host.write(RESET_CTRL_ADDR, 8'h80);
      hit(7, 1, 1'b0);
      $display("source test done");
      tally_and_finish();
   end
endmodule : board_reset_config_bench
bind board_reset_config board_reset_config_chk chk (.clock, .reset, .board_chip_select, .writeStrobe,
   .readStrobe, .address, .writeData, .readData, .supervisorReset_n, .probeHardReset_n, .hardButton_n,
   .edge_connector_present, .power_on_reset_n, .hard_reset_n, .soft_reset_n, .pciClockFromEdge);
`default_nettype wire
